// file: logic/fbpc_consts.svh
// Purpose: constants of the parameter channel and break guard
// Assumes: 25 MHz system clock
// Notes:   included by the top module
`ifndef FBPC_CONSTS_SVH
`define FBPC_CONSTS_SVH

// ----------------------------------------
// Request and response codes
// ----------------------------------------
`define RQ_NONE      4'h0
`define RQ_RD_WORD   4'h1
`define RQ_WR_WORD   4'h2
`define RQ_RD_ARR    4'h6
`define RQ_WR_ARR    4'h7
`define RSP_WORD_OK  4'h1
`define RSP_ARR_OK   4'h4
`define RSP_ERR      4'h7
`define ERR_NOPARAM  16'h0000
`define ERR_WR_INH   16'h0001
`define ERR_RANGE    16'h0002
`define ERR_SUBIDX   16'h0003

// ----------------------------------------
// Parameter numbers and values
// ----------------------------------------
`define PAR_REQ_SEL  16'h0393
`define PAR_RSP_SEL  16'h0394
`define PAR_NODE     16'h0396
`define PAR_WR_PERM  16'h039F
`define PAR_FAULT    16'h03B3
`define PAR_BAUD     16'h03C3
`define PAR_VER      16'h03C5
`define PAR_CMD      16'h03C7
`define PAR_STATE    16'h03C8
`define PAR_INIT     16'h03CA
`define IDX_F0       8'h01
`define IDX_F1       8'h09
`define IDX_F2       8'h11
`define IDX_F3       8'h19
`define SEL_IDX_MAX  8'h04
`define PROFILE_VER  16'h0002
`define WR_PERM_RST  1'h1
`define FLAG_MAX     16'h0001

// ----------------------------------------
// Register bus map and reset values
// ----------------------------------------
`define ADDR_CTRL    12'h000
`define ADDR_TIMEOUT 12'h004
`define ADDR_STATUS  12'h008
`define CTRL_RST     32'h0000_0000
`define TIMEOUT_RST  16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_NS   40
`define MS_TICK_NS   1000000
`define DS_PER_MS    7'h63
`endif

// file: logic/fbpc_pkg.sv
// Purpose: shared types of the parameter channel and break guard
// Assumes: nothing
// Notes:   constants live in fbpc_consts.svh
package fbpc_pkg;
    typedef struct packed {
        logic        valid;
        logic [3:0]  code;
        logic [15:0] pnum;
        logic [7:0]  sub;
        logic [15:0] value;
    } chan_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_DECEL,
        ST_DONE
    } guard_e;
endpackage

// file: logic/fieldbus_param_channel_break_guard.sv
// Purpose: parameter channel server and network-break guard
// Assumes: request and frame pulses synchronous to i_sys_clk
// Notes:   answer one cycle after the request pulse
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`include "fbpc_consts.svh"

module fieldbus_param_channel_break_guard #(
    parameter int TICK_CYC = `MS_TICK_NS / `SYS_CLK_NS
) (
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    // APB slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // Parameter channel
    input  wire fbpc_pkg::chan_s      i_req,
    output fbpc_pkg::chan_s           o_resp,
    // Drive state inputs
    input  wire logic [3:0][15:0]     i_fault_code,
    input  wire logic [3:0]           i_baud_code,
    input  wire logic [6:0]           i_node_addr,
    input  wire logic [15:0]          i_drive_command_word,
    input  wire logic [15:0]          i_drive_state_word,
    input  wire logic                 i_frame_rx,
    input  wire logic                 i_motor_stopped,
    input  wire logic                 i_alarm_reset,
    // Drive controls
    output logic [3:0][15:0]          o_pd_req_sel,
    output logic [3:0][15:0]          o_pd_rsp_sel,
    output logic                      o_settings_init,
    output logic                      o_coast_stop,
    output logic                      o_decel_stop,
    output logic                      o_network_break_trip,
    output logic                      o_power_indicator_red_flash,
    output logic                      o_offline_indicator_red
);

    // ----------------------------------------
    // Parameter decode
    // ----------------------------------------
    logic [15:0] req_sel_reg [4];
    logic [15:0] rsp_sel_reg [4];
    logic        wr_perm_reg;
    logic        init_val_reg;
    fbpc_pkg::chan_s resp_reg;
    logic        init_reg;

    wire [15:0] pn      = i_req.pnum;
    wire [7:0]  sb      = i_req.sub;
    wire        p_req   = pn == `PAR_REQ_SEL;
    wire        p_rsp   = pn == `PAR_RSP_SEL;
    wire        p_perm  = pn == `PAR_WR_PERM;
    wire        p_fault = pn == `PAR_FAULT;
    wire        p_init  = pn == `PAR_INIT;
    wire        known   = p_req | p_rsp | p_perm | p_fault | p_init | pn == `PAR_NODE
                          | pn == `PAR_BAUD | pn == `PAR_VER | pn == `PAR_CMD | pn == `PAR_STATE;
    wire        arr_par = p_req | p_rsp | p_fault;
    wire        sel_ok  = sb != 8'h00 && sb <= `SEL_IDX_MAX;
    wire [1:0]  aidx    = 2'(sb - 8'h01);
    wire        arr_cd  = i_req.code == `RQ_RD_ARR || i_req.code == `RQ_WR_ARR;
    wire        wr_cd   = i_req.code == `RQ_WR_WORD || i_req.code == `RQ_WR_ARR;
    wire        served  = arr_cd || i_req.code == `RQ_RD_WORD || i_req.code == `RQ_WR_WORD;
    wire        idx_ok  = p_fault | ((p_req | p_rsp) & sel_ok);
    wire        shape_ok = arr_cd ? (arr_par & idx_ok) : !arr_par;
    wire        ro_par  = !(p_req | p_rsp | p_perm | p_init);
    wire        wr_inh  = wr_cd & !wr_perm_reg & !p_perm;
    wire        rng_bad = wr_cd & (p_perm | p_init) & i_req.value > `FLAG_MAX;
    wire        failed  = !known | !shape_ok | (wr_cd & ro_par) | wr_inh | rng_bad;
    wire [15:0] err_code = !known                     ? `ERR_NOPARAM :
                           !shape_ok                  ? `ERR_SUBIDX  :
                           (wr_cd & ro_par) | wr_inh  ? `ERR_WR_INH  :
                                                        `ERR_RANGE;
    wire [15:0] fault_val = sb == `IDX_F0 ? i_fault_code[0] :
                            sb == `IDX_F1 ? i_fault_code[1] :
                            sb == `IDX_F2 ? i_fault_code[2] :
                            sb == `IDX_F3 ? i_fault_code[3] : 16'h0000;
    // link rate and other read values
    wire [15:0] rd_val = p_req   ? req_sel_reg[aidx] :
                         p_rsp   ? rsp_sel_reg[aidx] :
                         p_fault ? fault_val :
                         p_perm  ? {15'h0000, wr_perm_reg} :
                         p_init  ? {15'h0000, init_val_reg} :
                         pn == `PAR_NODE  ? {9'h000, i_node_addr} :
                         pn == `PAR_BAUD  ? {12'h000, i_baud_code} :
                         pn == `PAR_VER   ? `PROFILE_VER :
                         pn == `PAR_CMD   ? i_drive_command_word : i_drive_state_word;
    wire        do_wr   = i_req.valid & served & wr_cd & !failed;
    wire [3:0]  rsp_cd  = !served ? `RQ_NONE : failed ? `RSP_ERR : arr_cd ? `RSP_ARR_OK : `RSP_WORD_OK;
    wire [15:0] rsp_val = failed ? err_code : wr_cd ? i_req.value : rd_val;
    wire        init_go = do_wr & p_init & init_val_reg & i_req.value == 16'h0000;

    // ----------------------------------------
    // Parameter storage and answer
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    req_sel_reg[g] <= 16'h0000;
                    rsp_sel_reg[g] <= 16'h0000;
                end else if (do_wr && aidx == 2'(g)) begin
                    if (p_req) req_sel_reg[g] <= i_req.value;
                    if (p_rsp) rsp_sel_reg[g] <= i_req.value;
                end
            end
            assign o_pd_req_sel[g] = req_sel_reg[g];
            assign o_pd_rsp_sel[g] = rsp_sel_reg[g];
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_perm_reg  <= `WR_PERM_RST;
            init_val_reg <= 1'b0;
            init_reg     <= 1'b0;
            resp_reg     <= '0;
        end else begin
            if (do_wr && p_perm) wr_perm_reg <= i_req.value[0];
            if (do_wr && p_init) init_val_reg <= i_req.value[0];
            init_reg       <= init_go;
            resp_reg.valid <= i_req.valid;
            if (i_req.valid) begin
                resp_reg.code  <= rsp_cd;
                resp_reg.pnum  <= pn;
                resp_reg.sub   <= sb;
                resp_reg.value <= rsp_val;
            end
        end
    end
    assign o_resp          = resp_reg;
    assign o_settings_init = init_reg;

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic [3:0]  act_reg;
    logic [9:0]  dly_set_reg;
    logic [15:0] tmo_reg;
    logic        trip_reg;
    logic        coast_reg;
    logic        brk_reg;
    logic        seen_reg;
    fbpc_pkg::guard_e st_reg;
    fbpc_pkg::guard_e st_next;

    wire        a_ctrl = i_paddr == `ADDR_CTRL;
    wire        a_tmo  = i_paddr == `ADDR_TIMEOUT;
    wire        a_stat = i_paddr == `ADDR_STATUS;
    wire        a_hit  = a_ctrl | a_tmo | a_stat;
    wire        acc    = i_psel & i_penable;
    wire        bus_wr = acc & i_pwrite;
    wire [31:0] stat_w = {26'h0000000, wr_perm_reg, o_decel_stop, coast_reg, seen_reg, brk_reg, trip_reg};
    assign o_pready  = 1'b1;
    assign o_pslverr = acc & (!a_hit | (i_pwrite & a_stat));
    assign o_prdata  = !acc ? 32'h0000_0000 :
                       a_ctrl ? {6'h00, dly_set_reg, 12'h000, act_reg} :
                       a_tmo  ? {16'h0000, tmo_reg} :
                       a_stat ? stat_w : 32'h0000_0000;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act_reg     <= 4'(`CTRL_RST);
            dly_set_reg <= 10'h000;
            tmo_reg     <= `TIMEOUT_RST;
        end else begin
            if (bus_wr && a_ctrl) begin
                act_reg     <= i_pwdata[3:0];
                dly_set_reg <= i_pwdata[25:16];
            end
            if (bus_wr && a_tmo) tmo_reg <= i_pwdata[15:0];
        end
    end

    // ----------------------------------------
    // Ticks and link watchdog
    // ----------------------------------------
    logic [15:0] ms_cnt_reg;
    logic [6:0]  ds_cnt_reg;
    logic [15:0] wd_cnt_reg;
    logic [9:0]  dly_cnt_reg;

    wire ms_tick = ms_cnt_reg == 16'(TICK_CYC - 1);
    wire ds_tick = ms_tick && ds_cnt_reg == `DS_PER_MS;
    wire brk_now  = seen_reg && !i_frame_rx && tmo_reg != 16'h0000 && wd_cnt_reg >= tmo_reg;
    wire brk_rise = brk_now && !brk_reg;
    wire m_imm    = act_reg == 4'h0 || (act_reg >= 4'h4 && act_reg <= 4'h9);
    wire m_run    = act_reg == 4'h3 || act_reg >= 4'hD;
    wire m_dec    = act_reg == 4'hA;
    wire m_rec    = act_reg == 4'h2 || act_reg == 4'hC;
    wire m_ddec   = act_reg == 4'hB || act_reg == 4'hC;
    wire dly_done = dly_cnt_reg == 10'h000;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ms_cnt_reg <= 16'h0000;
            ds_cnt_reg <= 7'h00;
            wd_cnt_reg <= 16'h0000;
            seen_reg   <= 1'b0;
            brk_reg    <= 1'b0;
        end else begin
            ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
            if (ms_tick) ds_cnt_reg <= ds_tick ? 7'h00 : ds_cnt_reg + 7'h01;
            if (i_frame_rx) wd_cnt_reg <= 16'h0000;
            else if (ms_tick && wd_cnt_reg != 16'hFFFF) wd_cnt_reg <= wd_cnt_reg + 16'h0001;
            if (i_frame_rx) seen_reg <= 1'b1;
            brk_reg <= brk_now;
        end
    end

    // ----------------------------------------
    // Break action sequencer
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            fbpc_pkg::ST_IDLE: begin
                if (brk_rise) begin
                    if (m_imm) st_next = fbpc_pkg::ST_DONE;
                    else if (m_dec) st_next = fbpc_pkg::ST_DECEL;
                    else if (!m_run) st_next = fbpc_pkg::ST_DELAY;
                end
            end
            fbpc_pkg::ST_DELAY: begin
                if (m_rec && i_frame_rx) st_next = fbpc_pkg::ST_IDLE;
                else if (dly_done) st_next = m_ddec ? fbpc_pkg::ST_DECEL : fbpc_pkg::ST_DONE;
            end
            fbpc_pkg::ST_DECEL: begin
                if (i_motor_stopped) st_next = fbpc_pkg::ST_DONE;
            end
            fbpc_pkg::ST_DONE: begin
                if (i_alarm_reset) st_next = fbpc_pkg::ST_IDLE;
            end
            default: st_next = fbpc_pkg::ST_IDLE;
        endcase
    end

    wire trip_set = st_reg != fbpc_pkg::ST_DONE && st_next == fbpc_pkg::ST_DONE;
    wire coast_set = trip_set && st_reg != fbpc_pkg::ST_DECEL;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg      <= fbpc_pkg::ST_IDLE;
            dly_cnt_reg <= 10'h000;
            trip_reg    <= 1'b0;
            coast_reg   <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (brk_rise && st_reg == fbpc_pkg::ST_IDLE) dly_cnt_reg <= dly_set_reg;
            else if (st_reg == fbpc_pkg::ST_DELAY && m_rec && i_frame_rx) dly_cnt_reg <= 10'h000;
            else if (ds_tick && !dly_done) dly_cnt_reg <= dly_cnt_reg - 10'h001;
            if (trip_set) trip_reg <= 1'b1;
            else if (i_alarm_reset) trip_reg <= 1'b0;
            if (coast_set) coast_reg <= 1'b1;
            else if (i_alarm_reset) coast_reg <= 1'b0;
        end
    end
    assign o_network_break_trip = trip_reg;
    assign o_coast_stop         = coast_reg;
    assign o_decel_stop         = st_reg == fbpc_pkg::ST_DECEL;
    assign o_power_indicator_red_flash = brk_reg;
    assign o_offline_indicator_red     = brk_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    arr_read_ok_a: assert property (i_req.valid && i_req.code == `RQ_RD_ARR && !failed |=>
        o_resp.code == `RSP_ARR_OK && o_resp.pnum == $past(i_req.pnum)) else $error("array read code");
    bad_index_a: assert property (i_req.valid && i_req.code == `RQ_RD_ARR && known && !shape_ok |=>
        o_resp.code == `RSP_ERR && o_resp.value == `ERR_SUBIDX) else $error("bad index answer");
    write_gate_a: assert property (i_req.valid && wr_cd && !wr_perm_reg && p_req |=>
        $stable(req_sel_reg[0]) && o_resp.code == `RSP_ERR) else $error("write gate");
    fault_zero_a: assert property (i_req.valid && i_req.code == `RQ_RD_ARR && p_fault && sb == 8'h02 |=>
        o_resp.value == 16'h0000) else $error("fault history zero");
    init_edge_a: assert property (o_settings_init |-> $past(init_val_reg) && !init_val_reg)
        else $error("init edge");
    no_early_a: assert property (!seen_reg |-> !brk_now && !trip_set) else $error("break before frame");
    imm_trip_a: assert property (brk_rise && m_imm && st_reg == fbpc_pkg::ST_IDLE |=>
        trip_reg && coast_reg) else $error("immediate trip");
    run_on_a: assert property (brk_rise && m_run && st_reg == fbpc_pkg::ST_IDLE |=>
        st_reg == fbpc_pkg::ST_IDLE && !trip_set && o_offline_indicator_red) else $error("run on");
    decel_trip_a: assert property (o_decel_stop && !i_motor_stopped |=> !$rose(trip_reg))
        else $error("trip before stop");
    trip_hold_a: assert property (trip_reg && !i_alarm_reset |=> trip_reg) else $error("trip lost");

    wire dly_exit = st_reg == fbpc_pkg::ST_DELAY && dly_done && !(m_rec && i_frame_rx);
    perm_write_a: assert property (i_req.valid && i_req.code == `RQ_WR_WORD && p_perm && !rng_bad |=>
        wr_perm_reg == $past(i_req.value[0])) else $error("permit write");
    sel_write_a: assert property (do_wr && p_req && aidx == 2'h3 |=>
        o_pd_req_sel[3] == $past(i_req.value)) else $error("request selector");
    rsp_write_a: assert property (do_wr && p_rsp && aidx == 2'h3 |=>
        o_pd_rsp_sel[3] == $past(i_req.value)) else $error("response selector");
    fault_idx_a: assert property (i_req.valid && i_req.code == `RQ_RD_ARR && p_fault && sb == `IDX_F2 |=>
        o_resp.value == $past(i_fault_code[2])) else $error("fault history entry");
    rate_read_a: assert property (i_req.valid && i_req.code == `RQ_RD_WORD && pn == `PAR_BAUD |=>
        o_resp.value == {12'h000, $past(i_baud_code)}) else $error("link rate");
    echo_field_a: assert property (i_req.valid |=>
        o_resp.pnum == $past(pn) && o_resp.sub == $past(sb)) else $error("echo fields");
    err_answer_a: assert property (i_req.valid && served && failed |=> o_resp.code == `RSP_ERR)
        else $error("error answer");
    rec_ignore_a: assert property (st_reg == fbpc_pkg::ST_DELAY && m_rec && i_frame_rx |=>
        st_reg == fbpc_pkg::ST_IDLE && !trip_reg) else $error("recovery ignored");
    delay_coast_a: assert property (dly_exit && !m_ddec |=> trip_reg && coast_reg)
        else $error("delayed coast");
    delay_decel_a: assert property (dly_exit && m_ddec |=> o_decel_stop && !trip_reg)
        else $error("delayed decel");
    dly_load_a: assert property (brk_rise && st_reg == fbpc_pkg::ST_IDLE |=>
        dly_cnt_reg == $past(dly_set_reg)) else $error("delay load");
    brk_flag_a: assert property (brk_now |=> o_offline_indicator_red)
        else $error("break flag");

endmodule

// file: sim/fbpc_master_model.sv
// Purpose: fieldbus master side of the parameter channel and frame stream
// Assumes: one request at a time
// Notes:   idle request fields show the inverse of the last request
`timescale 1ns/1ns

module fbpc_master_model (
    // Clock
    input  wire logic            i_sys_clk,
    // Channel to the device
    output fbpc_pkg::chan_s      o_req,
    output logic                 o_frame_rx,
    input  wire fbpc_pkg::chan_s i_resp
);
    initial begin
        o_req = '0;
        o_frame_rx = 1'b0;
    end

    // ----------------------------------------
    // Request and answer capture
    // ----------------------------------------
    task automatic request(input logic [3:0] code, input logic [15:0] pnum, input logic [7:0] sub,
                           input logic [15:0] value, output fbpc_pkg::chan_s resp, output logic ok);
        fbpc_pkg::chan_s r;
        r = '{1'b1, code, pnum, sub, (code == 4'h1 || code == 4'h6) ? 16'h0000 : value};
        @(posedge i_sys_clk);
        o_req <= r;
        @(posedge i_sys_clk);
        r = ~r;
        r.valid = 1'b0;
        o_req <= r;
        @(posedge i_sys_clk);
        resp = i_resp;
        ok = i_resp.valid;
    endtask

    // ----------------------------------------
    // One cyclic frame
    // ----------------------------------------
    task automatic frame();
        @(posedge i_sys_clk);
        o_frame_rx <= 1'b1;
        @(posedge i_sys_clk);
        o_frame_rx <= 1'b0;
    endtask
endmodule

// file: sim/testbench.sv
// Purpose: self-checking bench of the parameter channel and break guard
// Assumes: TICK_CYC of 4, timeout 2 ms, delay 0.2 s
// Notes:   far side driven through the master model
`timescale 1ns/1ns

module testbench;
    typedef struct packed {
        logic [3:0]  code;
        logic [15:0] pnum;
        logic [7:0]  sub;
        logic [15:0] value;
        logic [3:0]  ecode;
        logic [15:0] evalue;
    } row_s;

    logic             clk = 1'b0;
    logic             arst_n = 1'b0;
    logic             psel = 1'b0;
    logic             pen = 1'b0;
    logic             power_indicator = 1'b0;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    fbpc_pkg::chan_s  req;
    fbpc_pkg::chan_s  resp;
    fbpc_pkg::chan_s  got;
    logic             frame;
    logic             stopped = 1'b0;
    logic             alarm_rst = 1'b0;
    logic [3:0][15:0] req_sel;
    logic [3:0][15:0] rsp_sel;
    logic             init;
    logic             coast;
    logic             decel;
    logic             trip;
    logic             flash;
    logic             offline;
    logic             ok;
    logic [31:0]      q;
    int               n_mismatch = 0;
    int               checks_done = 0;
    int               n_init = 0;
    wire logic [4:0]  watch = {flash, decel, coast, trip, offline};

    always #20 clk = ~clk;
    always @(posedge clk) if (init === 1'b1) n_init++;

    fieldbus_param_channel_break_guard #(.TICK_CYC(4)) u_fieldbus_param_channel_break_guard (
        .i_sys_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(power_indicator),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_req(req), .o_resp(resp), .i_fault_code({16'h5500, 16'h3211, 16'h2301, 16'h7511}),
        .i_baud_code(4'h6), .i_node_addr(7'h05), .i_drive_command_word(16'h047F),
        .i_drive_state_word(16'h0237), .i_frame_rx(frame), .i_motor_stopped(stopped),
        .i_alarm_reset(alarm_rst), .o_pd_req_sel(req_sel), .o_pd_rsp_sel(rsp_sel), .o_settings_init(init),
        .o_coast_stop(coast), .o_decel_stop(decel), .o_network_break_trip(trip),
        .o_power_indicator_red_flash(flash), .o_offline_indicator_red(offline));

    fbpc_master_model u_fbpc_master_model (.i_sys_clk(clk), .o_req(req), .o_frame_rx(frame), .i_resp(resp));

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        checks_done++;
        if (act !== exp) begin
            n_mismatch++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    task automatic chk_resp(input fbpc_pkg::chan_s exp, input fbpc_pkg::chan_s act);
        checks_done++;
        if (act !== exp) begin
            n_mismatch++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] eq,
                       input logic eerr);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, power_indicator, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                n_mismatch++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        if (!wr) chk(eq, prdata);
        chk(32'(eerr), 32'(pslverr));
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wait_bit(input int idx, input int lim);
        for (int n = 0; watch[idx] !== 1'b1; n++) begin
            if (n == lim) begin
                n_mismatch++;
                report_and_stop();
            end
            @(posedge clk);
        end
    endtask

    task automatic alarm_pulse();
        @(posedge clk);
        alarm_rst <= 1'b1;
        @(posedge clk);
        alarm_rst <= 1'b0;
        stopped <= 1'b0;
    endtask

    row_s rows [25] = '{
        '{4'h1, 16'h039F, 8'h00, 16'h0000, 4'h1, 16'h0001}, '{4'h6, 16'h03B3, 8'h01, 16'h0000, 4'h4, 16'h7511},
        '{4'h6, 16'h03B3, 8'h09, 16'h0000, 4'h4, 16'h2301}, '{4'h6, 16'h03B3, 8'h11, 16'h0000, 4'h4, 16'h3211},
        '{4'h6, 16'h03B3, 8'h19, 16'h0000, 4'h4, 16'h5500}, '{4'h6, 16'h03B3, 8'h02, 16'h0000, 4'h4, 16'h0000},
        '{4'h1, 16'h03B3, 8'h01, 16'h0000, 4'h7, 16'h0003}, '{4'h7, 16'h03B3, 8'h01, 16'h0001, 4'h7, 16'h0001},
        '{4'h1, 16'h03C3, 8'h00, 16'h0000, 4'h1, 16'h0006}, '{4'h1, 16'h03C5, 8'h00, 16'h0000, 4'h1, 16'h0002},
        '{4'h1, 16'h03C7, 8'h00, 16'h0000, 4'h1, 16'h047F}, '{4'h1, 16'h03C8, 8'h00, 16'h0000, 4'h1, 16'h0237},
        '{4'h1, 16'h0396, 8'h00, 16'h0000, 4'h1, 16'h0005}, '{4'h7, 16'h0393, 8'h01, 16'hABCD, 4'h4, 16'hABCD},
        '{4'h6, 16'h0393, 8'h01, 16'h0000, 4'h4, 16'hABCD}, '{4'h7, 16'h0393, 8'h04, 16'h1234, 4'h4, 16'h1234},
        '{4'h6, 16'h0393, 8'h05, 16'h0000, 4'h7, 16'h0003}, '{4'h7, 16'h0394, 8'h04, 16'h5A5A, 4'h4, 16'h5A5A},
        '{4'h6, 16'h0394, 8'h04, 16'h0000, 4'h4, 16'h5A5A}, '{4'h2, 16'h039F, 8'h00, 16'h0000, 4'h1, 16'h0000},
        '{4'h7, 16'h0393, 8'h02, 16'h1111, 4'h7, 16'h0001}, '{4'h2, 16'h039F, 8'h00, 16'h0002, 4'h7, 16'h0002},
        '{4'h2, 16'h039F, 8'h00, 16'h0001, 4'h1, 16'h0001}, '{4'h1, 16'h0100, 8'h00, 16'h0000, 4'h7, 16'h0000},
        '{4'h2, 16'h03C3, 8'h00, 16'h0001, 4'h7, 16'h0001}};

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        chk(32'h1, 32'(pready));
        chk(32'h0, 32'({watch, init, coast}));
        chk_resp('0, resp);
        @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        bus(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
        bus(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        bus(1'b1, 12'h008, 32'h1, 32'h0, 1'b1);
        bus(1'b1, 12'h004, 32'h2, 32'h0, 1'b0);
        bus(1'b0, 12'h004, 32'h0, 32'h2, 1'b0);
        for (int i = 0; i < 25; i++) begin
            u_fbpc_master_model.request(rows[i].code, rows[i].pnum, rows[i].sub, rows[i].value, got, ok);
            chk(32'h1, 32'(ok));
            chk_resp({1'b1, rows[i].ecode, rows[i].pnum, rows[i].sub, rows[i].evalue}, got);
        end
        chk(32'h1234ABCD, {req_sel[3], req_sel[0]});
        chk(32'h5A5A0000, {rsp_sel[3], rsp_sel[0]});
        u_fbpc_master_model.request(4'h2, 16'h03CA, 8'h00, 16'h0001, got, ok);
        u_fbpc_master_model.request(4'h2, 16'h03CA, 8'h00, 16'h0000, got, ok);
        repeat (3) @(posedge clk);
        chk(32'h1, 32'(n_init));
        u_fbpc_master_model.request(4'h2, 16'h03CA, 8'h00, 16'h0000, got, ok);
        repeat (3) @(posedge clk);
        chk(32'h1, 32'(n_init));
        repeat (40) @(posedge clk);
        chk(32'h0, 32'(watch));
        bus(1'b0, 12'h008, 32'h0, 32'h20, 1'b0);
        for (int m = 0; m < 16; m++) begin
            bus(1'b1, 12'h000, {6'h00, 10'h002, 12'h000, 4'(m)}, 32'h0, 1'b0);
            alarm_pulse();
            u_fbpc_master_model.frame();
            @(posedge clk);
            chk(32'h0, 32'(watch[0]));
            wait_bit(0, 30);
            if (m inside {1, 2, 11, 12}) chk(32'h0, 32'(watch[3:1]));
            if (m inside {0, [4:9]}) begin
                repeat (2) @(posedge clk);
                chk(32'h17, 32'(watch));
            end else if (m inside {1, 2}) begin
                wait_bit(1, 1000);
                @(posedge clk);
                chk(32'h1, 32'(coast));
            end else if (m inside {[10:12]}) begin
                wait_bit(3, (m == 10) ? 3 : 1000);
                chk(32'h0, 32'(trip));
                stopped <= 1'b1;
                wait_bit(1, 10);
            end else begin
                repeat (900) @(posedge clk);
                chk(32'h11, 32'(watch));
            end
            if (m == 0) bus(1'b0, 12'h008, 32'h0, 32'h2F, 1'b0);
            alarm_pulse();
            repeat (4) @(posedge clk);
            chk(32'h0, 32'(watch[3:1]));
        end
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 12'h000, {6'h00, 10'h002, 12'h000, (k == 0) ? 4'h2 : 4'hC}, 32'h0, 1'b0);
            alarm_pulse();
            u_fbpc_master_model.frame();
            @(posedge clk);
            wait_bit(0, 30);
            repeat (420) u_fbpc_master_model.frame();
            chk(32'h0, 32'(watch[3:0]));
        end
        arst_n <= 1'b0;
        @(posedge clk);
        chk(32'h0, 32'(watch));
        arst_n <= 1'b1;
        repeat (40) @(posedge clk);
        chk(32'h0, 32'(watch));
        bus(1'b0, 12'h008, 32'h0, 32'h20, 1'b0);
        report_and_stop();
    end
endmodule
